// ### core/llk_pkg.sv
/*
 * Shared constants for the load-immediate-and-link decode block: field
 * positions of the 36-bit instruction word, the opcode, mode codes and
 * reset values.
 * Assumes bit 0 of the documented word is the most significant bit, so
 * documented bit n sits at vector index 35-n.
 */
package llk_pkg;

    localparam int          WORD_W       = 36;
    localparam int          DATA_W       = 18;
    // Field positions, given as vector indices.
    localparam int          OPC_HI       = 35;
    localparam int          OPC_LO       = 27;
    localparam int          REG_HI       = 26;
    localparam int          REG_LO       = 23;
    localparam int          IND_BIT      = 22;
    localparam int          MODE_HI      = 21;
    localparam int          MODE_LO      = 18;
    localparam int          IMM_HI       = 17;
    localparam int          IMM_LO       = 0;
    // Opcode 020 octal in the top nine bits.
    localparam logic [8:0]  LDL_OPCODE   = 9'h010;
    // Target register code that selects the program counter.
    localparam logic [3:0]  REG_PC       = 4'h2;
    // Mode codes; zero in the mode field means no mode change.
    localparam logic [3:0]  MODE_KEEP          = 4'h0;
    localparam logic [3:0]  program_mode_code  = 4'h1;
    localparam logic [3:0]  execute_mode_code  = 4'h2;
    localparam logic [3:0]  repeat_mode_code   = 4'h3;
    // Reset values.
    localparam logic [3:0]  MODE_RESET   = 4'h1;
    localparam logic [17:0] PC_RESET     = 18'h00000;
    localparam logic [17:0] AUX_RESET    = 18'h00000;

    typedef enum logic [0:0] {
        LLK_FETCH,
        LLK_WAIT
    } llk_state_t;

endpackage

// ### core/llk_decode.sv
/*
 * Field decoder for one instruction word. Purely combinational.
 * Assumes the word is stable while the caller samples the outputs.
 */
`timescale 1ns/1ps
module llk_decode (
    input  wire logic [35:0] word,
    input  wire logic        mod_fitted,
    output logic             is_ldl,
    output logic [3:0]       reg_sel,
    output logic             indirect,
    output logic [3:0]       mode_field,
    output logic [17:0]      imm
);
    // Opcode match is gated by the option strap so an unmodified unit
    // passes the word on as an ordinary group-0 instruction.
    assign is_ldl     = mod_fitted &&
        (word[llk_pkg::OPC_HI:llk_pkg::OPC_LO] == llk_pkg::LDL_OPCODE);
    assign reg_sel    = word[llk_pkg::REG_HI:llk_pkg::REG_LO];
    assign indirect   = word[llk_pkg::IND_BIT];
    assign mode_field = word[llk_pkg::MODE_HI:llk_pkg::MODE_LO];
    assign imm        = word[llk_pkg::IMM_HI:llk_pkg::IMM_LO];
endmodule

// ### core/llk_core.sv
/*
 * Channel-control fetch and execute logic for the load-immediate-and-link
 * instruction and its linked-jump form, including execute-mode fetching
 * through the auxiliary fetch-address register.
 * Assumes host memory answers each one-cycle read request with exactly
 * one mem_rvalid pulse, at least one cycle later, and that all inputs are
 * synchronous to clk.
 */
`timescale 1ns/1ps
module llk_core #(
    parameter int AW = 18
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          run,
    input  wire logic          mod_fitted,
    input  wire logic          repeat_count_pos,
    output logic               mem_req,
    output logic [AW-1:0]      mem_addr,
    input  wire logic [35:0]   mem_rdata,
    input  wire logic          mem_rvalid,
    output logic               reg_wr,
    output logic [3:0]         reg_sel,
    output logic [17:0]        reg_data,
    output logic               insn_valid,
    output logic [35:0]        insn_word,
    output logic [AW-1:0]      pc,
    output logic [AW-1:0]      aux_fetch_address_reg,
    output logic [3:0]         mode
);

    // The address registers hold at most the 18-bit immediate field.
    if (AW < 1 || AW > llk_pkg::DATA_W) begin : g_aw_check
        $error("llk_core: AW must lie between 1 and 18");
    end

    typedef struct packed {
        llk_pkg::llk_state_t st;
        logic [AW-1:0]       pc;
        logic [AW-1:0]       aux;
        logic [3:0]          mode;
        logic                req;
        logic [AW-1:0]       addr;
        logic                wr;
        logic [3:0]          sel;
        logic [17:0]         data;
        logic                iv;
        logic [35:0]         iw;
    } llk_regs_t;

    llk_regs_t r_r;
    llk_regs_t r_nxt;

    logic        d_ldl;
    logic [3:0]  d_reg;
    logic        d_ind;
    logic [3:0]  d_mode;
    logic [17:0] d_imm;
    logic        accept;
    logic        ldl_go;
    logic        from_aux;

    llk_decode u_field (
        .word       (mem_rdata),
        .mod_fitted (mod_fitted),
        .is_ldl     (d_ldl),
        .reg_sel    (d_reg),
        .indirect   (d_ind),
        .mode_field (d_mode),
        .imm        (d_imm)
    );

    assign accept   = (r_r.st == llk_pkg::LLK_WAIT) && mem_rvalid;
    assign ldl_go   = accept && d_ldl;
    assign from_aux = (r_r.mode == llk_pkg::execute_mode_code);

    // Next-state logic: issue fetches, then retire the returned word.
    always_comb begin
        r_nxt     = r_r;
        r_nxt.req = 1'b0;
        r_nxt.wr  = 1'b0;
        r_nxt.iv  = 1'b0;
        case (r_r.st)
            llk_pkg::LLK_FETCH: begin
                if (run) begin
                    r_nxt.req = 1'b1;
                    r_nxt.st  = llk_pkg::LLK_WAIT;
                    if (from_aux) begin
                        r_nxt.addr = r_r.aux;
                        r_nxt.aux  = r_r.aux + 1'b1;
                    end else begin
                        r_nxt.addr = r_r.pc;
                        r_nxt.pc   = r_r.pc + 1'b1;
                    end
                end
            end
            llk_pkg::LLK_WAIT: begin
                if (mem_rvalid) begin
                    r_nxt.st = llk_pkg::LLK_FETCH;
                    if (d_ldl) begin
                        r_nxt.aux = r_r.addr + 1'b1;
                        if (!d_ind) begin
                            if (d_reg == llk_pkg::REG_PC) begin
                                r_nxt.pc = d_imm[AW-1:0];
                            end else begin
                                r_nxt.wr   = 1'b1;
                                r_nxt.sel  = d_reg;
                                r_nxt.data = d_imm;
                            end
                        end
                    end else begin
                        // Everything else goes to the rest of the unit.
                        r_nxt.iv = 1'b1;
                        r_nxt.iw = mem_rdata;
                    end
                end
            end
            default: begin
                r_nxt.st = llk_pkg::LLK_FETCH;
            end
        endcase
        // A mode carried by the instruction outranks the repeat exit, so
        // a chained jump can re-enter execute mode in the same cycle.
        if (ldl_go && d_mode != llk_pkg::MODE_KEEP) begin
            r_nxt.mode = d_mode;
        end else if (from_aux && repeat_count_pos) begin
            r_nxt.mode = llk_pkg::program_mode_code;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            r_r      <= '0;
            r_r.st   <= llk_pkg::LLK_FETCH;
            r_r.pc   <= llk_pkg::PC_RESET[AW-1:0];
            r_r.aux  <= llk_pkg::AUX_RESET[AW-1:0];
            r_r.mode <= llk_pkg::MODE_RESET;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign mem_req               = r_r.req;
    assign mem_addr              = r_r.addr;
    assign reg_wr                = r_r.wr;
    assign reg_sel               = r_r.sel;
    assign reg_data              = r_r.data;
    assign insn_valid            = r_r.iv;
    assign insn_word             = r_r.iw;
    assign pc                    = r_r.pc;
    assign aux_fetch_address_reg = r_r.aux;
    assign mode                  = r_r.mode;

    // Checks on decode, linking and fetch-source switching.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_LOAD_IMM: assert property (
        ldl_go && !d_ind && d_reg != llk_pkg::REG_PC |=>
        reg_wr && reg_sel == $past(d_reg) && reg_data == $past(d_imm))
        else $error("immediate load not issued");
    AST_DECODE_OPC: assert property (
        accept && mod_fitted &&
        mem_rdata[llk_pkg::OPC_HI:llk_pkg::OPC_LO] != llk_pkg::LDL_OPCODE |=>
        insn_valid && !reg_wr)
        else $error("non-matching opcode was not passed on");
    AST_NOT_FITTED: assert property (
        accept && !mod_fitted |=> insn_valid && !reg_wr)
        else $error("instruction decoded without the option");
    AST_LINK: assert property (
        ldl_go |=> aux_fetch_address_reg == $past(mem_addr) + 1'b1)
        else $error("auxiliary register not linked");
    AST_JUMP: assert property (
        ldl_go && !d_ind && d_reg == llk_pkg::REG_PC |=>
        pc == $past(d_imm[AW-1:0]) && !reg_wr)
        else $error("linked jump did not load pc");
    AST_EXEC_FETCH: assert property (
        r_r.st == llk_pkg::LLK_FETCH && run && from_aux |=>
        mem_req && mem_addr == $past(aux_fetch_address_reg) &&
        pc == $past(pc))
        else $error("execute mode fetch not from auxiliary");
    AST_AUX_INC: assert property (
        r_r.st == llk_pkg::LLK_FETCH && run && from_aux |=>
        aux_fetch_address_reg == $past(aux_fetch_address_reg) + 1'b1)
        else $error("auxiliary register not incremented");
    AST_RPT_EXIT: assert property (
        from_aux && repeat_count_pos && !ldl_go ##1
        r_r.st == llk_pkg::LLK_FETCH && run |=>
        mem_req && mem_addr == $past(pc, 1))
        else $error("repeat exit did not return to pc fetch");
    AST_INDIRECT: assert property (
        ldl_go && d_ind |=> !reg_wr && pc == $past(pc))
        else $error("indirect form loaded a register");
    AST_MODE_SET: assert property (
        ldl_go && d_mode != llk_pkg::MODE_KEEP |=> mode == $past(d_mode))
        else $error("mode field not applied");
    // Outside execute mode the program counter feeds the fetch and the
    // auxiliary register must keep its linked value for a later jump.
    AST_PC_FETCH: assert property (
        r_r.st == llk_pkg::LLK_FETCH && run && !from_aux |=>
        mem_req && mem_addr == $past(pc) && pc == $past(pc) + 1'b1 &&
        aux_fetch_address_reg == $past(aux_fetch_address_reg))
        else $error("program mode fetch not from pc");
    AST_ONE_RESULT: assert property (
        !(reg_wr && insn_valid))
        else $error("word both decoded and passed on");

    COV_JUMP_EXEC: cover property (
        ldl_go && d_reg == llk_pkg::REG_PC &&
        d_mode == llk_pkg::execute_mode_code);
    COV_EXEC_FETCH: cover property (mem_req && from_aux);
    COV_RPT_EXIT: cover property (from_aux && repeat_count_pos ##1 !from_aux);
    COV_REG_LOAD: cover property (reg_wr);

endmodule

// ### bench/llk_host_mem.sv
/*
 * Host memory model that answers the fetch unit's read requests.
 * Assumes one outstanding read; slow stretches each answer to four cycles.
 */
`timescale 1ns/1ps
module llk_host_mem (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic [17:0] mem_addr,
    output logic      [35:0] mem_rdata,
    output logic             mem_rvalid
);
    logic [35:0] mem [0:63];
    logic [2:0]  cnt;
    logic [5:0]  adr;

    // Outside a valid beat the data lines toggle, so stale data never
    // looks like a fresh answer.
    always_ff @(posedge clk) begin
        mem_rvalid <= 1'b0;
        mem_rdata  <= ~mem_rdata;
        if (rst) begin
            cnt <= 3'h0;
        end else if (mem_req) begin
            cnt <= slow ? 3'h4 : 3'h1;
            adr <= mem_addr[5:0];
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
                mem_rvalid <= 1'b1;
                mem_rdata  <= mem[adr];
            end
        end
    end
endmodule

// ### bench/tb_load_immediate_link_decode.sv
/*
 * Self-checking bench for the fetch unit, fed by the host memory model.
 * Assumes the fetch unit starts at address zero after reset.
 */
`timescale 1ns/1ps
module tb_load_immediate_link_decode;
    logic clk, rst, run, fit, rpos, slow, req, rv, wr, iv;
    logic [17:0] addr, pc, aux, rdat;
    logic [35:0] rd, iw;
    logic [3:0]  sel, mode;
    int          err_total, n_checks;

    llk_core #(.AW(18)) dut_u (.clk(clk), .rst(rst), .run(run),
        .mod_fitted(fit), .repeat_count_pos(rpos), .mem_req(req),
        .mem_addr(addr), .mem_rdata(rd), .mem_rvalid(rv), .reg_wr(wr),
        .reg_sel(sel), .reg_data(rdat), .insn_valid(iv), .insn_word(iw),
        .pc(pc), .aux_fetch_address_reg(aux), .mode(mode));
    llk_host_mem mem_u (.clk(clk), .rst(rst), .slow(slow), .mem_req(req),
        .mem_addr(addr), .mem_rdata(rd), .mem_rvalid(rv));

    // Builds an instruction word of the load-and-link kind.
    function automatic logic [35:0] mk_ldl(logic [3:0] r, logic i,
                                        logic [3:0] m, logic [17:0] d);
        return {llk_pkg::LDL_OPCODE, r, i, m, d};
    endfunction

    task automatic chk(logic [35:0] got, logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    // Waits a bounded time for the next request and checks its address.
    task automatic wait_req(logic [17:0] a);
        bit ok;
        ok = 0;
        for (int i = 0; i < 40 && !ok; i++) begin
            @(posedge clk);
            #1;
            ok = (req === 1'b1);
        end
        chk(ok, 1);
        chk(addr, a);
    endtask

    task automatic wait_out();
        bit ok;
        ok = 0;
        for (int i = 0; i < 40 && !ok; i++) begin
            @(posedge clk);
            #1;
            ok = (wr === 1'b1) || (iv === 1'b1);
        end
        chk(ok, 1);
    endtask

    task automatic t_load();
        chk(mode, llk_pkg::MODE_RESET);
        wait_req(18'h00000);
        wait_out();
        chk({wr, iv, sel}, {2'b10, 4'h5});
        chk(rdat, 18'h01234);
        chk(aux, 18'h00001);
        wait_req(18'h00001);
        wait_out();
        chk({wr, iv}, 2'b01);
        chk(iw, 36'h001ABCDEF);
        $display("test load done");
    endtask

    // The jump is answered slowly to show the answer spacing is free.
    task automatic t_jump();
        @(negedge clk) slow = 1'b1;
        wait_req(18'h00002);
        // Memory latches the stretch one edge after the request shows.
        @(posedge clk);
        @(negedge clk) slow = 1'b0;
        wait_req(18'h00003);
        chk(pc, 18'h00010);
        chk(mode, llk_pkg::execute_mode_code);
        chk(aux, 18'h00004);
        wait_req(18'h00004);
        chk(aux, 18'h00005);
        $display("test jump done");
    endtask

    // The count turns positive as a data word retires, so the very next
    // fetch must already come from the program counter.
    task automatic t_exit();
        bit seen;
        seen = 0;
        for (int i = 0; i < 40 && !seen; i++) begin
            @(posedge clk);
            #1;
            seen = (rv === 1'b1);
        end
        chk(seen, 1);
        @(negedge clk) rpos = 1'b1;
        @(posedge clk);
        #1;
        chk(mode, llk_pkg::program_mode_code);
        @(negedge clk) rpos = 1'b0;
        wait_req(18'h00010);
        $display("test exit done");
    endtask

    // Indirect form loads nothing but still links; then the strap is off.
    task automatic t_ind_strap();
        wait_req(18'h00011);
        chk(aux, 18'h00011);
        chk(rdat, 18'h01234);
        @(negedge clk) fit = 1'b0;
        wait_out();
        chk({wr, iv}, 2'b01);
        chk(iw, mk_ldl(4'h5, 1'b0, 4'h0, 18'h00777));
        @(negedge clk) run = 1'b0;
        $display("test indirect and strap done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #20000;
        err_total++;
        wrap_up();
    end

    // Program image, reset, then the scenarios in fetch order.
    initial begin
        {rst, run, fit, rpos, slow} = 5'b11100;
        err_total = 0;
        n_checks  = 0;
        for (int i = 0; i < 64; i++) mem_u.mem[i] = 36'h0;
        mem_u.mem[0]  = mk_ldl(4'h5, 1'b0, 4'h0, 18'h01234);
        mem_u.mem[1]  = 36'h001ABCDEF;
        mem_u.mem[2]  = mk_ldl(4'h2, 1'b0, 4'h2, 18'h00010);
        mem_u.mem[3]  = 36'h00000AAAA;
        mem_u.mem[4]  = 36'h000005555;
        mem_u.mem[16] = mk_ldl(4'h5, 1'b1, 4'h0, 18'h03FFF);
        mem_u.mem[17] = mk_ldl(4'h5, 1'b0, 4'h0, 18'h00777);
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_load();
        t_jump();
        t_exit();
        t_ind_strap();
        wrap_up();
    end
endmodule
